// file: common/filter_csr_pkg.sv
package filter_csr_pkg;

  // ------------------------------------------------------------
  // Register layout
  // ------------------------------------------------------------
  localparam int unsigned DATA_WIDTH            = 24;
  localparam int unsigned FIFO_DEPTH            = 4;
  localparam int unsigned BUFFER_DEPTH          = 8;
  localparam logic [23:0] CSR_RESET             = 24'h000000;
  localparam logic [23:0] CSR_RESERVED_MASK     = 24'hFF0200;
  localparam logic [23:0] CSR_WRITABLE_MASK     = 24'h000DFF;
  localparam int unsigned OUTPUT_FULL_POS       = 15;
  localparam int unsigned INPUT_EMPTY_POS       = 14;
  localparam int unsigned CONFLICT_POS          = 13;
  localparam int unsigned OVERFLOW_POS          = 12;
  localparam int unsigned OUTPUT_IRQ_EN_POS     = 11;
  localparam int unsigned INPUT_IRQ_EN_POS      = 10;
  localparam int unsigned SHARED_COEFF_POS      = 8;
  localparam int unsigned STATE_INIT_DIS_POS    = 7;
  localparam int unsigned MULTICHANNEL_POS      = 6;
  localparam int unsigned FIR_OP_LSB            = 4;
  localparam int unsigned COEFF_UPDATE_POS      = 3;
  localparam int unsigned ADAPTIVE_POS          = 2;
  localparam int unsigned FILTER_TYPE_POS       = 1;
  localparam int unsigned UNIT_ENABLE_POS       = 0;

  typedef enum logic [1:0] {
    FIR_REAL      = 2'h0,
    FIR_COMPLEX   = 2'h1,
    FIR_ALTERNATE = 2'h2,
    FIR_MAGNITUDE = 2'h3
  } fir_operation_type;

endpackage : filter_csr_pkg

// file: core/sample_fifo.sv
`timescale 1ns/1ps
module sample_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (level != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid = (level != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      end
      if (push && !pop) begin
        level <= level + 1'b1;
      end else if (pop && !push) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule : sample_fifo

// file: core/filter_control_status.sv
`timescale 1ns/1ps
module filter_control_status
  import filter_csr_pkg::*;
#(
  parameter int unsigned WIDTH       = DATA_WIDTH,
  parameter int unsigned QUEUE_DEPTH = FIFO_DEPTH,
  parameter int unsigned BUF_DEPTH   = BUFFER_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             soft_reset,
  input  wire logic             csr_write,
  input  wire logic [23:0]      csr_wdata,
  output logic      [23:0]      csr_rdata,
  input  wire logic             sample_write,
  input  wire logic [WIDTH-1:0] sample_wdata,
  input  wire logic             result_read,
  output logic      [WIDTH-1:0] result_rdata,
  output logic                  core_sample_valid,
  input  wire logic             core_sample_ready,
  output logic      [WIDTH-1:0] core_sample_data,
  input  wire logic             core_result_valid,
  output logic                  core_result_ready,
  input  wire logic [WIDTH-1:0] core_result_data,
  input  wire logic             memory_conflict,
  input  wire logic             arith_overflow,
  input  wire logic             coeff_update_done,
  output logic                  unit_active,
  output logic                  fir_selected,
  output logic      [1:0]       fir_operation_select,
  output logic                  state_init_enable,
  output logic                  multichannel_enable,
  output logic                  shared_coeff_select,
  output logic                  coeff_update_request,
  output logic                  adaptive_enable,
  output logic                  input_irq,
  output logic                  output_irq
);

  // ------------------------------------------------------------
  // Control bits
  // ------------------------------------------------------------
  logic [23:0] control;
  logic        unit_enable_bit;
  logic        input_irq_enable;
  logic        output_irq_enable;
  logic        filter_type_select;
  logic        state_init_disable;
  logic        memory_conflict_flag;
  logic        arith_overflow_flag;
  logic        output_full_flag;
  logic        input_empty_flag;
  logic [WIDTH-1:0] result_output_register;
  logic        queue_in_ready;
  logic        queue_out_valid;
  logic [WIDTH-1:0] queue_out_data;
  logic [$clog2(QUEUE_DEPTH+1)-1:0] queue_level;
  logic        buf_in_valid;
  logic        buf_in_ready;
  logic        buf_out_valid;
  logic        buf_out_ready;
  logic [WIDTH-1:0] buf_out_data;
  logic [$clog2(BUF_DEPTH+1)-1:0] buf_level;
  logic        update_set;
  logic        unit_on;
  logic        sample_taken;
  localparam int unsigned BL_W = $clog2(BUF_DEPTH + 1);

  assign unit_enable_bit    = control[UNIT_ENABLE_POS];
  assign filter_type_select = control[FILTER_TYPE_POS];
  assign state_init_disable = control[STATE_INIT_DIS_POS];
  assign input_irq_enable   = control[INPUT_IRQ_EN_POS];
  assign output_irq_enable  = control[OUTPUT_IRQ_EN_POS];
  assign unit_on            = unit_enable_bit && !soft_reset;
  // The queue head leaves only on a real handshake of the registered valid
  assign sample_taken       = core_sample_valid && core_sample_ready && unit_on;
  // Adaptive mode re-arms an update on every pass while in FIR
  assign update_set = control[ADAPTIVE_POS] && !filter_type_select && unit_on;

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  // Reserved bits are masked, so they read zero whatever software writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      control <= CSR_RESET;
    end else if (soft_reset) begin
      control <= CSR_RESET;
    end else begin
      if (csr_write) begin
        control <= csr_wdata & CSR_WRITABLE_MASK;
      end
      // Completion clears the request, but adaptive mode set wins
      if (update_set || (csr_write && csr_wdata[COEFF_UPDATE_POS])) begin
        control[COEFF_UPDATE_POS] <= 1'b1;
      end else if (coeff_update_done) begin
        control[COEFF_UPDATE_POS] <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Sticky status flags
  // ------------------------------------------------------------
  // A csr write clears both flags; a same-cycle conflict, or overflow while the unit is on, keeps it set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      memory_conflict_flag <= 1'b0;
    end else if (soft_reset) begin
      memory_conflict_flag <= 1'b0;
    end else if (memory_conflict) begin
      memory_conflict_flag <= 1'b1;
    end else if (csr_write) begin
      memory_conflict_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arith_overflow_flag <= 1'b0;
    end else if (soft_reset) begin
      arith_overflow_flag <= 1'b0;
    end else if (arith_overflow && unit_on) begin
      arith_overflow_flag <= 1'b1;
    end else if (csr_write) begin
      arith_overflow_flag <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Sample input queue and result path
  // ------------------------------------------------------------
  // Writes to a full queue are dropped; software must wait for empty
  sample_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (QUEUE_DEPTH)
  ) u_input_queue (
    .clk       (clk),
    .rst_n     (rst_n && unit_on),
    .in_valid  (sample_write),
    .in_ready  (queue_in_ready),
    .in_data   (sample_wdata),
    .out_valid (queue_out_valid),
    .out_ready (sample_taken),
    .out_data  (queue_out_data),
    .level     (queue_level)
  );

  // Results buffered so the filter core stalls only when 8 are pending
  sample_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (BUF_DEPTH)
  ) u_result_buffer (
    .clk       (clk),
    .rst_n     (rst_n && unit_on),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (core_result_data),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data),
    .level     (buf_level)
  );

  // Ready is registered, so it is only raised when a slot is sure to stay free
  assign buf_in_valid  = core_result_valid && core_result_ready && unit_on;
  assign buf_out_ready = !output_full_flag || result_read;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      output_full_flag       <= 1'b0;
      result_output_register <= '0;
    end else if (!unit_on) begin
      output_full_flag       <= 1'b0;
      result_output_register <= '0;
    end else if (buf_out_valid && buf_out_ready) begin
      output_full_flag       <= 1'b1;
      result_output_register <= buf_out_data;
    end else if (result_read) begin
      output_full_flag       <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      input_empty_flag <= 1'b0;
    end else if (!unit_on) begin
      input_empty_flag <= 1'b0;
    end else if (sample_write) begin
      input_empty_flag <= 1'b0;
    end else begin
      input_empty_flag <= (queue_level == '0);
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_sample_valid <= 1'b0;
      core_sample_data  <= '0;
      core_result_ready <= 1'b0;
      result_rdata      <= '0;
    end else begin
      // One idle cycle after each transfer lets the head word settle
      core_sample_valid <= queue_out_valid && unit_on && !sample_taken;
      core_sample_data  <= queue_out_data;
      core_result_ready <= buf_in_ready && unit_on
                           && !(buf_in_valid && buf_level == BL_W'(BUF_DEPTH - 1));
      result_rdata      <= result_output_register;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_active          <= 1'b0;
      fir_selected         <= 1'b0;
      fir_operation_select <= FIR_REAL;
      state_init_enable    <= 1'b0;
      multichannel_enable  <= 1'b0;
      shared_coeff_select  <= 1'b0;
      coeff_update_request <= 1'b0;
      adaptive_enable      <= 1'b0;
    end else begin
      unit_active          <= unit_on;
      fir_selected         <= !filter_type_select;
      fir_operation_select <= filter_type_select ? FIR_REAL
                              : control[FIR_OP_LSB +: 2];
      state_init_enable    <= !filter_type_select && !state_init_disable;
      multichannel_enable  <= control[MULTICHANNEL_POS];
      shared_coeff_select  <= control[MULTICHANNEL_POS]
                              && control[SHARED_COEFF_POS];
      coeff_update_request <= !filter_type_select && control[COEFF_UPDATE_POS];
      adaptive_enable      <= !filter_type_select && control[ADAPTIVE_POS];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      input_irq  <= 1'b0;
      output_irq <= 1'b0;
    end else begin
      input_irq  <= input_irq_enable && input_empty_flag;
      output_irq <= output_irq_enable && output_full_flag;
    end
  end

  // ------------------------------------------------------------
  // Read-back view
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      csr_rdata <= CSR_RESET;
    end else begin
      csr_rdata                    <= control & ~CSR_RESERVED_MASK;
      csr_rdata[OUTPUT_FULL_POS]   <= output_full_flag;
      csr_rdata[INPUT_EMPTY_POS]   <= input_empty_flag;
      csr_rdata[CONFLICT_POS]      <= memory_conflict_flag;
      csr_rdata[OVERFLOW_POS]      <= arith_overflow_flag;
    end
  end

endmodule : filter_control_status

// file: tb/filter_csr_sva.sv
`timescale 1ns/1ps
module filter_csr_sva
  import filter_csr_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        soft_reset,
  input wire logic        csr_write,
  input wire logic [23:0] csr_wdata,
  input wire logic [23:0] csr_rdata,
  input wire logic        memory_conflict,
  input wire logic        arith_overflow,
  input wire logic        coeff_update_done,
  input wire logic        unit_active,
  input wire logic        core_sample_valid,
  input wire logic        fir_selected,
  input wire logic        coeff_update_request,
  input wire logic        adaptive_enable,
  input wire logic        input_irq,
  input wire logic        output_irq
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  reserved_zero_a: assert property (csr_rdata[23:16] == 8'h00 && !csr_rdata[9])
    else $error("reserved bits read nonzero");
  soft_clear_a: assert property (soft_reset ##1 !(csr_write || memory_conflict || arith_overflow)
    |=> csr_rdata == 24'h000000) else $error("soft reset left bits set");
  ctrl_echo_a: assert property (csr_write && !soft_reset ##1 !csr_write && !soft_reset
    |=> {csr_rdata[11:10], csr_rdata[8:4], csr_rdata[1:0]} ==
        {$past(csr_wdata[11:10], 2), $past(csr_wdata[8:4], 2), $past(csr_wdata[1:0], 2)})
    else $error("control bits differ from written value");
  adapt_sets_a: assert property (adaptive_enable && fir_selected && unit_active
    |-> ##[0:2] coeff_update_request) else $error("adaptive mode left update clear");
  upd_done_a: assert property (coeff_update_request && coeff_update_done && !adaptive_enable
    && !csr_write ##1 !csr_write |-> ##[0:1] !coeff_update_request)
    else $error("update request not cleared");
  conflict_set_a: assert property (memory_conflict && unit_active && !soft_reset && !csr_write
    ##1 !soft_reset && !csr_write |=> csr_rdata[CONFLICT_POS]) else $error("conflict not flagged");
  sticky_hold_a: assert property ((csr_rdata[OVERFLOW_POS] && !csr_write && !soft_reset
    && unit_active) [*2] |=> csr_rdata[OVERFLOW_POS]) else $error("overflow flag dropped");
  out_gate_a: assert property (!csr_rdata[OUTPUT_IRQ_EN_POS] [*2] |-> !output_irq)
    else $error("output irq while disabled");
  in_gate_a: assert property (!csr_rdata[INPUT_IRQ_EN_POS] [*2] |-> !input_irq)
    else $error("input irq while disabled");
  idle_off_a: assert property (!unit_active [*3] |-> !(core_sample_valid || input_irq || output_irq))
    else $error("activity while unit disabled");
  cover property (csr_write ##2 csr_rdata[UNIT_ENABLE_POS]);
  cover property (output_irq);
  cover property (coeff_update_request && coeff_update_done);
endmodule : filter_csr_sva

// file: tb/filter_core_model.sv
`timescale 1ns/1ps
module filter_core_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        stall,
  input  wire logic        core_sample_valid,
  output logic             core_sample_ready,
  input  wire logic [23:0] core_sample_data,
  output logic             core_result_valid,
  input  wire logic        core_result_ready,
  output logic      [23:0] core_result_data
);
  // ----------------------------------------
  // One sample in flight, result is sample plus one
  // ----------------------------------------
  logic [23:0] held;
  assign core_sample_ready = !stall && !core_result_valid;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_result_valid <= 1'h0;
      held              <= 24'h000000;
    end else if (core_result_valid && core_result_ready) begin
      core_result_valid <= 1'h0;
    end else if (core_sample_valid && core_sample_ready) begin
      core_result_valid <= 1'h1;
      held              <= core_sample_data + 24'h000001;
    end
  end
  // Idle bus shows the inverse so stale data never passes for a result
  assign core_result_data = core_result_valid ? held : ~held;
endmodule : filter_core_model

// file: tb/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; $display("FAIL t=%0t got %0h exp %0h", $time, a, b); end end
module testbench;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic        clk = 1'h0, rst_n = 1'h0, soft_reset = 1'h0, csr_write = 1'h0, stall = 1'h1;
  logic        sample_write = 1'h0, result_read = 1'h0, memory_conflict = 1'h0;
  logic        arith_overflow = 1'h0, coeff_update_done = 1'h0;
  logic [23:0] csr_wdata = 24'h000000, sample_wdata = 24'h000000, csr_rdata, result_rdata;
  logic [23:0] core_sample_data, core_result_data, cfg;
  logic        core_sample_valid, core_sample_ready, core_result_valid, core_result_ready;
  logic        unit_active, fir_selected, state_init_enable, multichannel_enable, input_irq;
  logic        shared_coeff_select, coeff_update_request, adaptive_enable, output_irq;
  logic [1:0]  fir_operation_select;
  int          miscompares = 0, check_count = 0, n;
  always #20 clk = ~clk;
  filter_control_status filter_control_status_i (.clk, .rst_n, .soft_reset, .csr_write, .csr_wdata,
    .csr_rdata, .sample_write, .sample_wdata, .result_read, .result_rdata, .core_sample_valid,
    .core_sample_ready, .core_sample_data, .core_result_valid, .core_result_ready,
    .core_result_data, .memory_conflict, .arith_overflow, .coeff_update_done, .unit_active,
    .fir_selected, .fir_operation_select, .state_init_enable, .multichannel_enable,
    .shared_coeff_select, .coeff_update_request, .adaptive_enable, .input_irq, .output_irq);
  filter_core_model filter_core_model_i (.clk, .rst_n, .stall, .core_sample_valid,
    .core_sample_ready, .core_sample_data, .core_result_valid, .core_result_ready,
    .core_result_data);
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  // Idle cycle after each pulse keeps two writes of one signal out of a time step
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick(1);
    s = 1'h0;
    tick(1);
  endtask : pulse
  task automatic csr_wr(input logic [23:0] d);
    csr_wdata = d;
    pulse(csr_write);
  endtask : csr_wr
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic wait_full();
    for (n = 0; n < 200 && csr_rdata[15] !== 1'h1; n++) tick(1);
    if (n == 200) begin
      miscompares++;
      stop_test();
    end
  endtask : wait_full
  initial begin
    tick(2);
    rst_n = 1'h1;
    tick(1);
    `CHK(csr_rdata, 24'h000000);
    csr_wr(24'h000C01);
    tick(2);
    `CHK(csr_rdata & 24'hFF0FFF, 24'h000C01);
    `CHK({csr_rdata[14], input_irq, output_irq}, 3'h6);
    // Core stalled: four words fill the queue, the fifth must be dropped
    for (int i = 0; i < 5; i++) begin
      sample_wdata = 24'h000100 + 24'(i);
      pulse(sample_write);
    end
    tick(2);
    `CHK({csr_rdata[14], input_irq}, 2'h0);
    stall = 1'h0;
    for (int i = 0; i < 4; i++) begin
      wait_full();
      `CHK(output_irq, 1'h1);
      `CHK(result_rdata, 24'h000101 + 24'(i));
      pulse(result_read);
      tick(2);
    end
    tick(10);
    `CHK({csr_rdata[15], output_irq}, 2'h0);
    pulse(memory_conflict);
    pulse(arith_overflow);
    tick(6);
    `CHK(csr_rdata[13:12], 2'h3);
    csr_wr(24'h000001);
    tick(2);
    `CHK(csr_rdata[13:12], 2'h0);
    for (int i = 0; i < 4; i++) begin
      cfg = 24'h0001C0 | (24'(i) << 4);
      csr_wr(24'h000000);
      csr_wr(cfg);
      csr_wr(cfg | 24'h000001);
      tick(2);
      `CHK(fir_operation_select, 2'(i));
      `CHK({multichannel_enable, shared_coeff_select, state_init_enable}, 3'h6);
      `CHK({unit_active, fir_selected}, 2'h3);
    end
    csr_wr(24'h000000);
    csr_wr(24'h000002);
    csr_wr(24'h000003);
    tick(2);
    `CHK({unit_active, fir_selected}, 2'h2);
    csr_wr(24'h000000);
    csr_wr(24'h000001);
    csr_wr(24'h000009);
    tick(2);
    `CHK({coeff_update_request, state_init_enable}, 2'h3);
    pulse(coeff_update_done);
    tick(2);
    `CHK({coeff_update_request, csr_rdata[3]}, 2'h0);
    csr_wr(24'h000005);
    tick(2);
    `CHK({coeff_update_request, adaptive_enable}, 2'h3);
    pulse(soft_reset);
    tick(2);
    `CHK({csr_rdata, unit_active}, 25'h0000000);
    stop_test();
  end
endmodule : testbench
bind filter_control_status filter_csr_sva filter_csr_sva_i (.clk, .rst_n, .soft_reset,
  .csr_write, .csr_wdata, .csr_rdata, .memory_conflict, .arith_overflow, .coeff_update_done,
  .unit_active, .core_sample_valid, .fir_selected, .coeff_update_request, .adaptive_enable,
  .input_irq, .output_irq);
